// >>> pkg/retimer_pkg.sv
// Purpose: shared constants and types of the dual retimer path select block
// Assumes: 20 MHz system clock, one serial bit per clock cycle in the model
// Notes: times are in ns, cycle counts derive from them
package retimer_pkg;
   localparam int CLK_MHZ = 20;
   // half-rate synthesizer multiplies the reference by five, two bits per cycle
   localparam int SYNTH_MULT = 5;
   localparam int REF_PERIOD_CYC = 2 * SYNTH_MULT;
   localparam int REF_TOL_CYC = 1;
   localparam int REF_MISS_MAX = 4;
   localparam int REF_DOWN_CYC = REF_PERIOD_CYC * (REF_MISS_MAX + 1);
   localparam int T_INI_NS = 4000;
   localparam int T_LCK_NS = 1600;
   localparam int INI_CYC = (T_INI_NS * CLK_MHZ + 999) / 1000;
   localparam int LCK_CYC = (T_LCK_NS * CLK_MHZ + 999) / 1000;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 2;
   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RELOCKS = 8'h08;
   // control fields
   localparam int LOOP_A_BIT = 0;
   localparam int LOOP_B_BIT = 1;
   localparam int DRIVE_A_BIT = 2;
   localparam int DRIVE_B_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'hf;
   // status fields
   localparam int LOCKED_BIT = 0;
   localparam int RECOVER_BIT = 1;
   localparam int LEVEL_LSB = 4;
   typedef enum logic [1:0] {st_acquire, st_locked, st_recover} lock_state_t;
endpackage

// >>> rtl/dual_retimer_path_select.sv
// Purpose: lane retiming, loopback path select and driver enables, Wishbone registers
// Assumes: inputs synchronous to clk_i, serial bits arrive one per cycle
// Notes: retimed lane pairs pass through a small FIFO before the path mux
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// fifo with valid/ready on both sides
module retime_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // fill level
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;

   assign level_o = wr_ptr - rd_ptr;
   assign in_ready_o = (level_o != (AW+1)'(DEPTH));
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage is not reset, only the pointers say what is valid
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dual_retimer_path_select (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // reference clock, sampled as a level
   input wire logic ref_clk_i,
   // serial inputs
   input wire logic serial_in_a_i,
   input wire logic serial_in_b_i,
   input wire logic serial_valid_i,
   output logic serial_ready_o,
   // serial outputs
   output logic serial_out_a_o,
   output logic serial_out_b_o,
   output logic serial_out_valid_o,
   input wire logic out_ready_i,
   // driver enables and lock
   output logic out_drive_on_a_o,
   output logic out_drive_on_b_o,
   output logic locked_o
);
   localparam int LW = $clog2(retimer_pkg::FIFO_DEPTH) + 1;

   ////////////////////////////////////////////////////////////////////////////
   // control and status registers
   logic [3:0] ctrl, next_ctrl;
   logic [15:0] relocks, next_relocks;
   logic [31:0] next_dat;
   logic ack, next_ack;
   logic wr_en;
   logic [LW-1:0] level;
   retimer_pkg::lock_state_t state, next_state;
   logic loop_ctl_a_n, loop_ctl_b_n;

   assign loop_ctl_a_n = ctrl[retimer_pkg::LOOP_A_BIT];
   assign loop_ctl_b_n = ctrl[retimer_pkg::LOOP_B_BIT];
   assign out_drive_on_a_o = ctrl[retimer_pkg::DRIVE_A_BIT];
   assign out_drive_on_b_o = ctrl[retimer_pkg::DRIVE_B_BIT];
   assign wb_ack_o = ack;
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack;

   always_comb begin
      next_ack = wb_cyc_i && wb_stb_i && !ack;
      next_ctrl = ctrl;
      if (wr_en && wb_sel_i[0] && wb_adr_i == retimer_pkg::ADDR_CTRL) begin
         next_ctrl = wb_dat_i[3:0];
      end
      next_dat = '0;
      if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i) begin
         unique case (wb_adr_i)
            retimer_pkg::ADDR_CTRL: next_dat = {28'h0000000, ctrl};
            retimer_pkg::ADDR_STATUS: begin
               next_dat[retimer_pkg::LOCKED_BIT] = (state == retimer_pkg::st_locked);
               next_dat[retimer_pkg::RECOVER_BIT] = (state == retimer_pkg::st_recover);
               next_dat[retimer_pkg::LEVEL_LSB +: LW] = level;
            end
            retimer_pkg::ADDR_RELOCKS: next_dat = {16'h0000, relocks};
            default: next_dat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= retimer_pkg::CTRL_RESET;
         ack <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         ctrl <= next_ctrl;
         ack <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference clock monitor and lock state
   logic ref_q, ref_rise;
   logic [7:0] gap, next_gap;
   logic [7:0] timer, next_timer;
   logic period_ok, missing, link_down, bad_period;
   logic ref_seen, next_ref_seen;

   assign ref_rise = ref_clk_i && !ref_q;
   // expected period is two bits per synthesized cycle, five per reference
   assign period_ok = ref_rise
      && (gap + 8'h01 >= 8'(retimer_pkg::REF_PERIOD_CYC - retimer_pkg::REF_TOL_CYC))
      && (gap + 8'h01 <= 8'(retimer_pkg::REF_PERIOD_CYC + retimer_pkg::REF_TOL_CYC));
   assign missing = gap >= 8'(retimer_pkg::REF_PERIOD_CYC + retimer_pkg::REF_TOL_CYC);
   assign link_down = gap >= 8'(retimer_pkg::REF_DOWN_CYC);
   // the first rise after reset only starts the period count
   assign bad_period = ref_rise && ref_seen && !period_ok;
   assign locked_o = (state == retimer_pkg::st_locked);

   always_comb begin
      next_gap = ref_rise ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
      next_ref_seen = ref_seen || ref_rise;
      next_state = state;
      next_timer = timer;
      next_relocks = relocks;
      unique case (state)
         retimer_pkg::st_acquire: begin
            if (link_down || bad_period) begin
               next_timer = 8'h00;
            end else if (timer == 8'(retimer_pkg::INI_CYC - 1)) begin
               next_state = retimer_pkg::st_locked;
               next_timer = 8'h00;
            end else begin
               next_timer = timer + 8'h01;
            end
         end
         retimer_pkg::st_locked: begin
            if (link_down) begin
               next_state = retimer_pkg::st_acquire;
               next_timer = 8'h00;
            end else if (missing || bad_period) begin
               next_state = retimer_pkg::st_recover;
               next_timer = 8'h00;
               next_relocks = relocks + 16'h0001;
            end
         end
         retimer_pkg::st_recover: begin
            if (link_down) begin
               next_state = retimer_pkg::st_acquire;
               next_timer = 8'h00;
            end else if (missing || bad_period) begin
               next_timer = 8'h00;
            end else if (timer == 8'(retimer_pkg::LCK_CYC - 1)) begin
               next_state = retimer_pkg::st_locked;
               next_timer = 8'h00;
            end else begin
               next_timer = timer + 8'h01;
            end
         end
         default: begin
            next_state = retimer_pkg::st_acquire;
            next_timer = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= 1'b0;
         ref_seen <= 1'b0;
         gap <= 8'h00;
         timer <= 8'h00;
         relocks <= 16'h0000;
         state <= retimer_pkg::st_acquire;
      end else begin
         ref_q <= ref_clk_i;
         ref_seen <= next_ref_seen;
         gap <= next_gap;
         timer <= next_timer;
         relocks <= next_relocks;
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // retimed lane pairs buffered, then steered to the outputs
   logic fifo_valid, pop;
   logic [retimer_pkg::FIFO_WIDTH-1:0] fifo_data;
   logic next_out_a, next_out_b, next_out_valid;

   retime_fifo #(
      .WIDTH(retimer_pkg::FIFO_WIDTH),
      .DEPTH(retimer_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(serial_valid_i),
      .in_ready_o(serial_ready_o),
      .in_data_i({serial_in_b_i, serial_in_a_i}),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data),
      .level_o(level)
   );

   // output stage drains whenever it is empty or its bit is taken
   assign pop = !serial_out_valid_o || out_ready_i;

   always_comb begin
      next_out_a = serial_out_a_o;
      next_out_b = serial_out_b_o;
      next_out_valid = serial_out_valid_o && !out_ready_i;
      // bits keep flowing through relock so no bit is stretched or cut
      if (pop && fifo_valid) begin
         next_out_valid = 1'b1;
         if (!loop_ctl_a_n && loop_ctl_b_n) begin
            next_out_a = fifo_data[0];
            next_out_b = fifo_data[0];
         end else if (loop_ctl_a_n && !loop_ctl_b_n) begin
            next_out_a = fifo_data[1];
            next_out_b = fifo_data[1];
         end else if (!loop_ctl_a_n && !loop_ctl_b_n) begin
            next_out_a = fifo_data[0];
            next_out_b = fifo_data[1];
         end else begin
            next_out_a = fifo_data[1];
            next_out_b = fifo_data[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_a_o <= 1'b0;
         serial_out_b_o <= 1'b0;
         serial_out_valid_o <= 1'b0;
      end else begin
         serial_out_a_o <= next_out_a;
         serial_out_b_o <= next_out_b;
         serial_out_valid_o <= next_out_valid;
      end
   end
endmodule

// >>> verification/path_select_checker.sv
// Purpose: port checks of the path select block
// Assumes: one clock, synchronous reset
// Notes: bound to every instance
`timescale 1ns/1ps
module path_select_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // lanes
   input wire logic ref_clk_i,
   input wire logic serial_valid_i,
   input wire logic serial_ready_o,
   input wire logic serial_out_a_o,
   input wire logic serial_out_b_o,
   input wire logic serial_out_valid_o,
   input wire logic out_ready_i,
   input wire logic out_drive_on_a_o,
   input wire logic out_drive_on_b_o,
   input wire logic locked_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ref_q;
   logic [1:0] dat_q;
   logic [7:0] gap;
   always_ff @(posedge clk_i) begin
      ref_q <= ref_clk_i;
      dat_q <= wb_dat_i[3:2];
      if (rst_i || (ref_clk_i && !ref_q))
         gap <= 8'h00;
      else if (gap != 8'hff)
         gap <= gap + 8'h01;
   end
   ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h08 |->
      wb_dat_o == 32'h0) else $error("unmapped read not zero");
   drive_follow_a: assert property (
      wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] |=>
      {out_drive_on_b_o, out_drive_on_a_o} == dat_q) else $error("enables wrong");
   out_hold_a: assert property (serial_out_valid_o && !out_ready_i |=> serial_out_valid_o
      && $stable(serial_out_a_o) && $stable(serial_out_b_o)) else $error("output moved");
   push_out_a: assert property (
      serial_valid_i && serial_ready_o && !serial_out_valid_o |-> ##2 serial_out_valid_o)
      else $error("pair not forwarded");
   gap_drop_a: assert property (gap > 8'h0d |-> !locked_o)
      else $error("lock kept without reference");
endmodule
bind dual_retimer_path_select path_select_checker chk_u (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .ref_clk_i(ref_clk_i),
   .serial_valid_i(serial_valid_i),
   .serial_ready_o(serial_ready_o),
   .serial_out_a_o(serial_out_a_o),
   .serial_out_b_o(serial_out_b_o),
   .serial_out_valid_o(serial_out_valid_o),
   .out_ready_i(out_ready_i),
   .out_drive_on_a_o(out_drive_on_a_o),
   .out_drive_on_b_o(out_drive_on_b_o),
   .locked_o(locked_o)
);

// >>> verification/link_partner_model.sv
// Purpose: link partner: reference clock and output sink
// Assumes: reference period of ten system clocks
// Notes: stop and stall come from the bench
`timescale 1ns/1ps
module link_partner_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bench controls
   input wire logic ref_stop_i,
   input wire logic stall_i,
   input wire logic slow_i,
   // to the block
   output logic ref_clk_o,
   output logic out_ready_o
);
   logic [3:0] ph;
   always_ff @(posedge clk_i) begin
      // slow stretches the reference period by one clock, within tolerance
      if (rst_i || ph >= (slow_i ? 4'ha : 4'h9))
         ph <= 4'h0;
      else
         ph <= ph + 4'h1;
   end
   assign ref_clk_o = !ref_stop_i && ph < 4'h5;
   assign out_ready_o = !stall_i;
endmodule

// >>> verification/tb_dual_retimer_path_select.sv
// Purpose: register and lane tests of the path select block
// Assumes: ack one cycle after request, pairs popped in order
// Notes: partner gives reference and output ready
`timescale 1ns/1ps
module tb_dual_retimer_path_select;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, ref_clk_i, out_ready_i, serial_ready_o, serial_out_valid_o;
   logic serial_in_a_i = 1'b0, serial_in_b_i = 1'b0, serial_valid_i = 1'b0;
   logic serial_out_a_o, serial_out_b_o, out_drive_on_a_o, out_drive_on_b_o, locked_o;
   logic ref_stop = 1'b0, stall = 1'b0, slow = 1'b0;
   int error_cnt = 0, comparisons = 0;
   always #25 clk_i = ~clk_i;
   dual_retimer_path_select dut_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .ref_clk_i(ref_clk_i),
      .serial_in_a_i(serial_in_a_i),
      .serial_in_b_i(serial_in_b_i),
      .serial_valid_i(serial_valid_i),
      .serial_ready_o(serial_ready_o),
      .serial_out_a_o(serial_out_a_o),
      .serial_out_b_o(serial_out_b_o),
      .serial_out_valid_o(serial_out_valid_o),
      .out_ready_i(out_ready_i),
      .out_drive_on_a_o(out_drive_on_a_o),
      .out_drive_on_b_o(out_drive_on_b_o),
      .locked_o(locked_o)
   );
   link_partner_model lp_u (.clk_i(clk_i), .rst_i(rst_i), .ref_stop_i(ref_stop),
      .stall_i(stall), .slow_i(slow), .ref_clk_o(ref_clk_i), .out_ready_o(out_ready_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic push(input logic a, input logic b);
      serial_valid_i <= 1'b1;
      serial_in_a_i <= a;
      serial_in_b_i <= b;
      do begin
         @(posedge clk_i);
      end while (serial_ready_o !== 1'b1);
   endtask
   task automatic pop(input logic ea, input logic eb);
      do begin
         @(negedge clk_i);
      end while (!(serial_out_valid_o === 1'b1 && out_ready_i === 1'b1));
      chk({30'h0, serial_out_b_o, serial_out_a_o}, {30'h0, eb, ea});
      @(posedge clk_i);
   endtask
   initial begin
      #1000000;
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h0000000f);
      chk({30'h0, out_drive_on_b_o, out_drive_on_a_o}, 32'h3);
      for (int i = 0; i < 300 && locked_o !== 1'b1; i++) @(posedge clk_i);
      chk({31'h0, locked_o}, 32'h1);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 8'h00, {28'h0, m[1:0], m[1:0]}, q);
         chk({30'h0, out_drive_on_b_o, out_drive_on_a_o}, m);
         push(1'b1, 1'b0);
         push(1'b0, 1'b1);
         serial_valid_i <= 1'b0;
         pop(~m[0], m[1]);
         pop(m[0], ~m[1]);
      end
      bus(1'b1, 8'h00, 32'hf, q);
      stall <= 1'b1;
      for (int i = 0; i < 9; i++) push(i[0], i[1]);
      serial_valid_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, serial_ready_o}, 32'h0);
      bus(1'b0, 8'h04, 32'h0, q);
      chk({28'h0, q[7:4]}, retimer_pkg::FIFO_DEPTH);
      stall <= 1'b0;
      for (int i = 0; i < 9; i++) pop(i[1], i[0]);
      bus(1'b1, 8'h0c, 32'h0, q);
      bus(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h0);
      wb_sel_i <= 4'h0;
      bus(1'b1, 8'h00, 32'h0, q);
      wb_sel_i <= 4'h1;
      bus(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'hf);
      ref_stop <= 1'b1;
      repeat (retimer_pkg::REF_PERIOD_CYC * retimer_pkg::REF_MISS_MAX) @(posedge clk_i);
      chk({31'h0, locked_o}, 32'h0);
      ref_stop <= 1'b0;
      for (int i = 0; i < 300 && locked_o !== 1'b1; i++) @(posedge clk_i);
      chk({31'h0, locked_o}, 32'h1);
      slow <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk({31'h0, locked_o}, 32'h1);
      slow <= 1'b0;
      bus(1'b0, 8'h08, 32'h0, q);
      chk(q, 32'h1);
      close_out();
   end
endmodule
